// ===== design/bgp_pkg.sv
/*
  Package of the block-transfer geometry and pattern registers.
  Holds byte addresses, field positions, reset values and the carrier
  structs. Assumes a 32-bit register port with full byte addresses.
*/
package bgp_pkg;

  // Byte addresses of the registers
  localparam logic [31:0] BGP_ADDR_DEST_START   = 32'hB000_B040;
  localparam logic [31:0] BGP_ADDR_RECT_DIM     = 32'hB000_B044;
  localparam logic [31:0] BGP_ADDR_CLIP_TL      = 32'hB000_B048;
  localparam logic [31:0] BGP_ADDR_CLIP_BR      = 32'hB000_B04C;
  localparam logic [31:0] BGP_ADDR_PAT_LOW      = 32'hB000_B050;
  localparam logic [31:0] BGP_ADDR_PAT_HIGH     = 32'hB000_B054;

  // Reset values
  localparam logic [31:0] BGP_RST_DEST_START    = 32'h0000_0000;
  localparam logic [31:0] BGP_RST_RECT_DIM      = 32'h0000_0000;
  localparam logic [31:0] BGP_RST_CLIP_TL       = 32'h0000_0000;
  localparam logic [31:0] BGP_RST_CLIP_BR       = 32'h0000_0000;
  localparam logic [31:0] BGP_RST_PAT_LOW       = 32'h0000_0000;
  localparam logic [31:0] BGP_RST_PAT_HIGH      = 32'h0000_0000;
  localparam logic [31:0] BGP_RD_UNMAPPED       = 32'h0000_0000;

  // Field layout
  localparam int BGP_COORD_W   = 11;
  localparam int BGP_LIN_W     = 28;
  localparam int BGP_LO_LSB    = 0;
  localparam int BGP_HI_LSB    = 16;
  localparam int BGP_LIN_LSB   = 0;
  localparam int BGP_ROW_W     = 8;
  localparam int BGP_ROWS      = 8;

  typedef logic [BGP_COORD_W-1:0] bgp_coord_t;

  // Geometry fields the drawing engine reads from the registers
  typedef struct packed {
    logic [BGP_LIN_W-1:0]     dest_linear_start;
    bgp_coord_t               dest_start_x;
    bgp_coord_t               dest_start_y;
    bgp_coord_t               rect_width;
    bgp_coord_t               rect_height;
    bgp_coord_t               clip_top;
    bgp_coord_t               clip_left;
    bgp_coord_t               clip_bottom;
    bgp_coord_t               clip_right;
  } bgp_geom_t;

  // Pixel write offered by the engine for clipping
  typedef struct packed {
    logic                     valid;
    bgp_coord_t               x;
    bgp_coord_t               y;
  } bgp_pixel_t;

endpackage

// ===== design/bgp_regs.sv
/*
  Geometry and monochrome-pattern registers of the 2D engine, with the
  clipping gate on destination pixel writes and the pattern row lookup.
  Assumes a single-cycle register port: strobes one cycle long, never
  both at once; read data valid only in the cycle after the read.
*/
`timescale 1ns/10ps

// Notes on behaviour
// RQ1 - Linear destination start is 28-bit byte address
// RQ2 - Width is dimension bits 10 to 0
// RQ3 - Height is dimension bits 26 to 16
// RQ4 - Clip top from top/left bits 26:16
// RQ5 - Clip left from top/left bits 10:0
// RQ6 - Clip bottom from bottom/right bits 26:16
// RQ7 - Clip right from bottom/right bits 10:0
// RQ8 - Pattern rows one to four, low group bytes
// RQ9 - Pattern rows five to eight, high group bytes
// RQ10 - XY destination start from bits 10:0, 26:16
// RQ11 - Drop pixel writes outside clipping rectangle
module bgp_regs (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic [31:0]              reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [31:0]              reg_rdata,
  output bgp_pkg::bgp_geom_t            geom,
  input  wire logic [2:0]               pat_row_sel,
  output logic      [7:0]               pat_row_bits,
  input  wire bgp_pkg::bgp_pixel_t      pix_in,
  output logic                          pix_write,
  output logic                          pix_clipped
);

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  logic hit_dest_start;
  logic hit_rect_dimension;
  logic hit_clip_top_left;
  logic hit_clip_bottom_right;
  logic hit_pattern_rows_low;
  logic hit_pattern_rows_high;
  logic wr_dest_start;
  logic wr_rect_dimension;
  logic wr_clip_top_left;
  logic wr_clip_bottom_right;
  logic wr_pattern_rows_low;
  logic wr_pattern_rows_high;

  // Full address must match; other writes are dropped
  always_comb begin
    hit_dest_start        = (reg_addr == bgp_pkg::BGP_ADDR_DEST_START);
    hit_rect_dimension    = (reg_addr == bgp_pkg::BGP_ADDR_RECT_DIM);
    hit_clip_top_left     = (reg_addr == bgp_pkg::BGP_ADDR_CLIP_TL);
    hit_clip_bottom_right = (reg_addr == bgp_pkg::BGP_ADDR_CLIP_BR);
    hit_pattern_rows_low  = (reg_addr == bgp_pkg::BGP_ADDR_PAT_LOW);
    hit_pattern_rows_high = (reg_addr == bgp_pkg::BGP_ADDR_PAT_HIGH);
    wr_dest_start         = reg_wr && hit_dest_start;
    wr_rect_dimension     = reg_wr && hit_rect_dimension;
    wr_clip_top_left      = reg_wr && hit_clip_top_left;
    wr_clip_bottom_right  = reg_wr && hit_clip_bottom_right;
    wr_pattern_rows_low   = reg_wr && hit_pattern_rows_low;
    wr_pattern_rows_high  = reg_wr && hit_pattern_rows_high;
  end

  ////////////////////////////////////////////////////////////////////////
  // Destination start word
  // Linear and XY views share one store, as software sees it

  logic [31:0] dest_start;
  logic [31:0] next_dest_start;

  always_comb begin
    next_dest_start = dest_start;
    if (wr_dest_start) begin
      next_dest_start = reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dest_start <= bgp_pkg::BGP_RST_DEST_START;
    end else begin
      dest_start <= next_dest_start;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Rectangle dimension
  // Counts pixels in XY addressing and bytes in linear addressing

  logic [31:0] blit_rect_dimension;
  logic [31:0] next_blit_rect_dimension;

  always_comb begin
    next_blit_rect_dimension = blit_rect_dimension;
    if (wr_rect_dimension) begin
      next_blit_rect_dimension = reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      blit_rect_dimension <= bgp_pkg::BGP_RST_RECT_DIM;
    end else begin
      blit_rect_dimension <= next_blit_rect_dimension;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clipping top and left edges

  logic [31:0] clip_top_left;
  logic [31:0] next_clip_top_left;

  always_comb begin
    next_clip_top_left = clip_top_left;
    if (wr_clip_top_left) begin
      next_clip_top_left = reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clip_top_left <= bgp_pkg::BGP_RST_CLIP_TL;
    end else begin
      clip_top_left <= next_clip_top_left;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clipping bottom and right edges

  logic [31:0] clip_bottom_right;
  logic [31:0] next_clip_bottom_right;

  always_comb begin
    next_clip_bottom_right = clip_bottom_right;
    if (wr_clip_bottom_right) begin
      next_clip_bottom_right = reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clip_bottom_right <= bgp_pkg::BGP_RST_CLIP_BR;
    end else begin
      clip_bottom_right <= next_clip_bottom_right;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pattern rows one to four

  logic [31:0] pattern_rows_low;
  logic [31:0] next_pattern_rows_low;

  always_comb begin
    next_pattern_rows_low = pattern_rows_low;
    if (wr_pattern_rows_low) begin
      next_pattern_rows_low = reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pattern_rows_low <= bgp_pkg::BGP_RST_PAT_LOW;
    end else begin
      pattern_rows_low <= next_pattern_rows_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pattern rows five to eight

  logic [31:0] pattern_rows_high;
  logic [31:0] next_pattern_rows_high;

  always_comb begin
    next_pattern_rows_high = pattern_rows_high;
    if (wr_pattern_rows_high) begin
      next_pattern_rows_high = reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pattern_rows_high <= bgp_pkg::BGP_RST_PAT_HIGH;
    end else begin
      pattern_rows_high <= next_pattern_rows_high;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port

  logic [31:0] next_reg_rdata;

  // Whole words read back, so reserved bits return what was written
  always_comb begin
    next_reg_rdata = bgp_pkg::BGP_RD_UNMAPPED;
    if (reg_rd) begin
      unique case (reg_addr)
        bgp_pkg::BGP_ADDR_DEST_START: next_reg_rdata = dest_start;
        bgp_pkg::BGP_ADDR_RECT_DIM:   next_reg_rdata = blit_rect_dimension;
        bgp_pkg::BGP_ADDR_CLIP_TL:    next_reg_rdata = clip_top_left;
        bgp_pkg::BGP_ADDR_CLIP_BR:    next_reg_rdata = clip_bottom_right;
        bgp_pkg::BGP_ADDR_PAT_LOW:    next_reg_rdata = pattern_rows_low;
        bgp_pkg::BGP_ADDR_PAT_HIGH:   next_reg_rdata = pattern_rows_high;
        default:                      next_reg_rdata = bgp_pkg::BGP_RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= bgp_pkg::BGP_RD_UNMAPPED;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Field extraction for the engine

  always_comb begin
    geom.dest_linear_start =
      dest_start[bgp_pkg::BGP_LIN_LSB +: bgp_pkg::BGP_LIN_W];      // [RQ1]
    geom.dest_start_x =
      dest_start[bgp_pkg::BGP_LO_LSB +: bgp_pkg::BGP_COORD_W];     // [RQ10]
    geom.dest_start_y =
      dest_start[bgp_pkg::BGP_HI_LSB +: bgp_pkg::BGP_COORD_W];     // [RQ10]
    geom.rect_width =
      blit_rect_dimension[bgp_pkg::BGP_LO_LSB +: bgp_pkg::BGP_COORD_W];
                                                                   // [RQ2]
    geom.rect_height =
      blit_rect_dimension[bgp_pkg::BGP_HI_LSB +: bgp_pkg::BGP_COORD_W];
                                                                   // [RQ3]
    geom.clip_top =
      clip_top_left[bgp_pkg::BGP_HI_LSB +: bgp_pkg::BGP_COORD_W];   // [RQ4]
    geom.clip_left =
      clip_top_left[bgp_pkg::BGP_LO_LSB +: bgp_pkg::BGP_COORD_W];   // [RQ5]
    geom.clip_bottom =
      clip_bottom_right[bgp_pkg::BGP_HI_LSB +: bgp_pkg::BGP_COORD_W];
                                                                   // [RQ6]
    geom.clip_right =
      clip_bottom_right[bgp_pkg::BGP_LO_LSB +: bgp_pkg::BGP_COORD_W];
                                                                   // [RQ7]
  end

  ////////////////////////////////////////////////////////////////////////
  // Monochrome pattern row lookup, one cycle latency

  logic [bgp_pkg::BGP_ROW_W*bgp_pkg::BGP_ROWS-1:0] pattern_all;
  logic [7:0]                                     next_pat_row_bits;

  // Row n sits in byte n, low group first
  always_comb begin
    pattern_all       = {pattern_rows_high, pattern_rows_low}; // [RQ8] [RQ9]
    next_pat_row_bits =
      pattern_all[pat_row_sel*bgp_pkg::BGP_ROW_W +: bgp_pkg::BGP_ROW_W];
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pat_row_bits <= 8'h00;
    end else begin
      pat_row_bits <= next_pat_row_bits;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clipping gate, one cycle latency

  logic clear_left;
  logic clear_right;
  logic clear_top;
  logic clear_bottom;
  logic pix_in_clip;
  logic next_pix_write;
  logic next_pix_clipped;

  // Edges are inclusive; an inverted rectangle clips every pixel
  // Unsigned compares; coordinates are never negative
  always_comb begin
    clear_left       = (pix_in.x >= geom.clip_left);
    clear_right      = (pix_in.x <= geom.clip_right);
    clear_top        = (pix_in.y >= geom.clip_top);
    clear_bottom     = (pix_in.y <= geom.clip_bottom);
    pix_in_clip      = clear_left && clear_right
                    && clear_top && clear_bottom;
    next_pix_write   = pix_in.valid && pix_in_clip;             // [RQ11]
    next_pix_clipped = pix_in.valid && !pix_in_clip;            // [RQ11]
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pix_write   <= 1'b0;
      pix_clipped <= 1'b0;
    end else begin
      pix_write   <= next_pix_write;
      pix_clipped <= next_pix_clipped;
    end
  end

endmodule

// ===== verification/bgp_regs_assertions.sv
/*
  Checker of the geometry field views, the clipping gate and the idle read data.
  Bound to bgp_regs from the bench top; sees only its ports.
*/
`timescale 1ns/10ps
module bgp_regs_assertions (
  input wire logic                ref_clk,
  input wire logic                rst,
  input wire logic [31:0]         reg_addr,
  input wire logic [31:0]         reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [31:0]         reg_rdata,
  input wire bgp_pkg::bgp_geom_t  geom,
  input wire bgp_pkg::bgp_pixel_t pix_in,
  input wire logic                pix_write,
  input wire logic                pix_clipped
);
  logic [31:0] wd_q;
  wire logic   in_c = pix_in.x >= geom.clip_left
    && pix_in.x <= geom.clip_right && pix_in.y >= geom.clip_top
    && pix_in.y <= geom.clip_bottom;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Last write data, so field views can be tied to it
  always_ff @(posedge ref_clk or posedge rst)
    if (rst) wd_q <= '0;
    else wd_q <= reg_wdata;
  ////////////////////////////////////////////////////////////////////
  chk_dest_fields: assert property (
    reg_wr && reg_addr == bgp_pkg::BGP_ADDR_DEST_START |=>
    geom.dest_linear_start == wd_q[27:0] && geom.dest_start_x ==
    wd_q[10:0] && geom.dest_start_y == wd_q[26:16])
    else $error("destination start fields wrong");
  chk_dim_fields: assert property (
    reg_wr && reg_addr == bgp_pkg::BGP_ADDR_RECT_DIM |=>
    geom.rect_width == wd_q[10:0] && geom.rect_height == wd_q[26:16])
    else $error("dimension fields wrong");
  chk_clip_tl: assert property (
    reg_wr && reg_addr == bgp_pkg::BGP_ADDR_CLIP_TL |=>
    geom.clip_top == wd_q[26:16] && geom.clip_left == wd_q[10:0])
    else $error("top left clip fields wrong");
  chk_clip_br: assert property (
    reg_wr && reg_addr == bgp_pkg::BGP_ADDR_CLIP_BR |=>
    geom.clip_bottom == wd_q[26:16] && geom.clip_right == wd_q[10:0])
    else $error("bottom right clip fields wrong");
  chk_pix_pass: assert property (
    pix_in.valid && in_c |=> pix_write && !pix_clipped)
    else $error("inside pixel not written");
  chk_pix_drop: assert property (
    pix_in.valid && !in_c |=> pix_clipped && !pix_write)
    else $error("outside pixel not suppressed");
  chk_pix_idle: assert property (
    !pix_in.valid |=> !pix_write && !pix_clipped)
    else $error("pixel result without pixel");
  chk_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside read cycle");
endmodule

// ===== verification/bgp_regs_tb.sv
/*
  Self-checking bench of bgp_regs: registers, field views, pattern rows
  and clipping. Assumes the package and design are compiled first.
*/
`timescale 1ns/10ps
module bgp_regs_tb;
  logic                ref_clk, rst, reg_wr, reg_rd, pix_write, pix_clipped;
  logic [31:0]         reg_addr, reg_wdata, reg_rdata, seed;
  logic [2:0]          pat_row_sel;
  logic [7:0]          pat_row_bits;
  bgp_pkg::bgp_geom_t  geom;
  bgp_pkg::bgp_pixel_t pix_in;
  logic [31:0]         shadow [6];
  int                  mismatches, compares;
  bgp_regs DUT (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .geom, .pat_row_sel, .pat_row_bits, .pix_in, .pix_write,
    .pix_clipped);
  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] adr(int i);
    return bgp_pkg::BGP_ADDR_DEST_START + 32'(i) * 32'h0000_0004;
  endfunction
  // Edges inclusive
  function automatic logic in_clip(logic [10:0] x, logic [10:0] y);
    return x >= shadow[2][10:0] && x <= shadow[3][10:0]
      && y >= shadow[2][26:16] && y <= shadow[3][26:16];
  endfunction
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [31:0] a, logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [31:0] a, logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, e);
  endtask
  task automatic pix(logic [10:0] x, logic [10:0] y);
    @(posedge ref_clk);
    pix_in <= {1'b1, x, y};
    @(posedge ref_clk);
    pix_in <= '0;
    #1 chk("pix_write", 32'(pix_write), 32'(in_clip(x, y)));
    chk("pix_clipped", 32'(pix_clipped), 32'(!in_clip(x, y)));
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    close_out();
  end
  initial begin
    logic [63:0] pw;
    seed = 32'h8c20_f510;
    rst <= 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata, pat_row_sel, pix_in} <= '0;
    foreach (shadow[i]) shadow[i] = '0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) rd(adr(i), 32'h0000_0000);
    wr(32'hB000_B058, xs());
    rd(32'hB000_B058, 32'h0000_0000);
    repeat (4) begin
      for (int i = 0; i < 6; i++) begin
        shadow[i] = xs();
        wr(adr(i), shadow[i]);
      end
      for (int i = 0; i < 6; i++) rd(adr(i), shadow[i]);
      chk("lin", 32'(geom.dest_linear_start), {4'h0, shadow[0][27:0]});
      chk("dx", 32'(geom.dest_start_x), 32'(shadow[0][10:0]));
      chk("dy", 32'(geom.dest_start_y), 32'(shadow[0][26:16]));
      chk("w", 32'(geom.rect_width), 32'(shadow[1][10:0]));
      chk("h", 32'(geom.rect_height), 32'(shadow[1][26:16]));
      chk("top", 32'(geom.clip_top), 32'(shadow[2][26:16]));
      chk("left", 32'(geom.clip_left), 32'(shadow[2][10:0]));
      chk("bot", 32'(geom.clip_bottom), 32'(shadow[3][26:16]));
      chk("right", 32'(geom.clip_right), 32'(shadow[3][10:0]));
      pw = {shadow[5], shadow[4]};
      for (int r = 0; r < 8; r++) begin
        @(posedge ref_clk);
        pat_row_sel <= 3'(r);
        @(posedge ref_clk);
        #1 chk("row", 32'(pat_row_bits), 32'(pw[r*8 +: 8]));
      end
      repeat (6) pix(11'(xs()), 11'(xs()));
    end
    // Write then read with no idle cycle between the strobes
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= adr(1);
    reg_wdata <= 32'h0123_4567;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, 32'h0123_4567);
    shadow[2] = 32'h0014_000A;
    shadow[3] = 32'h00C8_0064;
    wr(adr(2), shadow[2]);
    wr(adr(3), shadow[3]);
    pix(11'd10, 11'd20);
    pix(11'd9, 11'd20);
    pix(11'd100, 11'd200);
    pix(11'd101, 11'd200);
    pix(11'd10, 11'd201);
    pix(11'd50, 11'd19);
    close_out();
  end
endmodule

bind bgp_regs bgp_regs_assertions u_chk (.ref_clk, .rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .geom, .pix_in, .pix_write,
  .pix_clipped);
